//--- core/adcseq_top.sv
// Conversion sequencer with its AHB-Lite register file
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "adcseq_defines.svh"
module adcseq_top import adcseq_pkg::*; #(
    parameter int BITS = 10,
    parameter int NCH = `ADCSEQ_CHANNELS
) (
    input wire logic clk, // 25 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, words only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic portb_analog_default, // Strap for port_config_lsb
    input wire logic [NCH-1:0] pin_level, // Digital level of each pin
    input wire logic [3:0] compare_two_mode, // Compare unit two mode
    input wire logic special_event_trig, // Compare unit two event
    input wire logic rc_tick, // internal_rc_clock period pulse
    input wire logic cmp_high, // Analog comparator result
    output logic irq, // Level interrupt
    output logic timer_clear, // Pulse: clear the associated timer
    output logic array_discharge, // Capacitor array discharge
    output logic sample_en, // Hold capacitor tracks the input
    output logic [3:0] channel_out, // Selected channel to the mux
    output logic [BITS-1:0] sar_code // Trial code to the DAC
);
    adcseq_state_t state, next_state;
    logic [7:0] res_hi, res_lo;
    logic [3:0] chs, pcfg;
    logic go, on, just, strap_done;
    logic [1:0] vref, status, mask;
    logic [2:0] acqt, adcs;
    logic [4:0] cnt;
    logic dph_wr;
    logic [7:0] dph_addr;

    // Bus decode
    wire aph = hsel && htrans[1] && hready;
    wire wr_ctrl = dph_wr && dph_addr == `ADCSEQ_CTRL_OFF;
    wire wr_cfg1 = dph_wr && dph_addr == `ADCSEQ_CFG1_OFF;
    wire wr_cfg2 = dph_wr && dph_addr == `ADCSEQ_CFG2_OFF;
    wire wr_hi = dph_wr && dph_addr == `ADCSEQ_RES_HI_OFF;
    wire wr_lo = dph_wr && dph_addr == `ADCSEQ_RES_LO_OFF;
    wire wr_stat = dph_wr && dph_addr == `ADCSEQ_STAT_OFF;
    wire wr_mask = dph_wr && dph_addr == `ADCSEQ_MASK_OFF;

    // Analog pin map; channel i is analog while i < 15 - config
    logic [NCH-1:0] analog;
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_an
            assign analog[gi] = ({1'b0, pcfg} + 5'(gi)) < `ADCSEQ_PCFG_NONE;
        end
    endgenerate
    wire [NCH-1:0] port_view = pin_level & ~analog;

    wire [7:0] ctrl_rd = {2'b00, chs, go, on};
    wire [7:0] cfg1_rd = {2'b00, vref, pcfg};
    wire [7:0] cfg2_rd = {just, 1'b0, acqt, adcs};
    wire [7:0] ra = haddr[7:0];
    wire [31:0] rd_mux =
        (ra == `ADCSEQ_RES_HI_OFF) ? {24'h0, res_hi} :
        (ra == `ADCSEQ_RES_LO_OFF) ? {24'h0, res_lo} :
        (ra == `ADCSEQ_CTRL_OFF) ? {24'h0, ctrl_rd} :
        (ra == `ADCSEQ_CFG1_OFF) ? {24'h0, cfg1_rd} :
        (ra == `ADCSEQ_CFG2_OFF) ? {24'h0, cfg2_rd} :
        (ra == `ADCSEQ_STAT_OFF) ? {30'h0, status} :
        (ra == `ADCSEQ_MASK_OFF) ? {30'h0, mask} :
        (ra == `ADCSEQ_PORT_OFF) ? {{(32-NCH){1'b0}}, port_view} :
        32'h0;

    // Zero wait states: read data is latched at the address phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            dph_wr <= aph && hwrite;
            dph_addr <= haddr[7:0];
            hrdata <= (aph && !hwrite) ? rd_mux : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Bit period timing
    logic tad_tick, sar_done;
    wire restart = (next_state != state);
    wire in_conv = state == ST_CONV;
    wire last_wait = cnt == 5'(`ADCSEQ_WAIT_TAD - 1);
    wire last_acq = cnt == adcseq_acq_tads(acqt) - 5'h01;
    wire last_dly = cnt == 5'(`ADCSEQ_INSTR_TOSC - 1);

    adcseq_tad_gen u_tad (
        .clk(clk),
        .rst_n(rst_n),
        .restart(restart),
        .clk_sel(adcs),
        .rc_tick(rc_tick),
        .tad_tick(tad_tick)
    );

    adcseq_sar #(.BITS(BITS)) u_sar (
        .clk(clk),
        .rst_n(rst_n),
        .start(restart && next_state == ST_CONV),
        .tad_tick(tad_tick),
        .cmp_high(cmp_high),
        .code(sar_code),
        .done(sar_done)
    );

    // Neither channel select nor pin direction enters the sequence
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: if (on) next_state = ST_WAIT;
            ST_WAIT: if (tad_tick && last_wait) next_state = ST_SAMPLE;
            ST_SAMPLE: if (go) begin
                // Manual mode stops sampling at once
                next_state = (acqt == 3'h0) ? ST_DELAY : ST_ACQ;
            end
            ST_ACQ: begin
                if (!go) next_state = ST_WAIT;
                else if (tad_tick && last_acq) next_state = ST_CONV;
            end
            ST_DELAY: begin
                if (!go) next_state = ST_WAIT;
                else if (last_dly) next_state = ST_CONV;
            end
            ST_CONV: if (!go || sar_done) next_state = ST_WAIT;
            default: next_state = ST_OFF;
        endcase
        if (!on) next_state = ST_OFF;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            cnt <= 5'h00;
        end else begin
            state <= next_state;
            if (restart) cnt <= 5'h00;
            else if (tad_tick || state == ST_DELAY) cnt <= cnt + 5'h01;
        end
    end

    // Trigger, completion and abort
    wire trig_hit = special_event_trig && compare_two_mode == `ADCSEQ_TRIG_MODE;
    wire trig_go = trig_hit && on;
    wire complete = in_conv && go && sar_done;
    wire abort = (in_conv || state == ST_ACQ || state == ST_DELAY) && !go;
    wire next_on = wr_ctrl ? hwdata[`ADCSEQ_CTRL_ON] : on;
    wire sw_go = wr_ctrl ? hwdata[`ADCSEQ_CTRL_GO] : (go && !complete);
    // A trigger in the completion cycle still sets go
    wire next_go = next_on && (sw_go || trig_go);

    // Result is written by a finished conversion or by a bus write; the conversion wins
    wire [BITS-1:0] r = sar_code;
    wire [7:0] new_hi = just ? {6'h00, r[9:8]} : r[9:2];
    wire [7:0] new_lo = just ? r[7:0] : {r[1:0], 6'h00};
    wire [1:0] ev = {abort, complete};
    wire [1:0] next_status = ev | (status & ~(wr_stat ? hwdata[1:0] : 2'b00));
    wire [1:0] next_mask = wr_mask ? hwdata[1:0] : mask;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on <= 1'b0;
            go <= 1'b0;
            chs <= 4'h0;
            res_hi <= 8'h00;
            res_lo <= 8'h00;
            status <= 2'b00;
            mask <= 2'b00;
        end else begin
            on <= next_on;
            go <= next_go;
            if (wr_ctrl) chs <= hwdata[`ADCSEQ_CTRL_CHS];
            if (complete) begin
                res_hi <= new_hi;
                res_lo <= new_lo;
            end else begin
                if (wr_hi) res_hi <= hwdata[7:0];
                if (wr_lo) res_lo <= hwdata[7:0];
            end
            status <= next_status;
            mask <= next_mask;
        end
    end

    // The strap is caught by the first clock after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done <= 1'b0;
            pcfg <= `ADCSEQ_PCFG_RST;
            vref <= 2'b00;
            just <= 1'b0;
            acqt <= 3'h0;
            adcs <= 3'h0;
        end else begin
            strap_done <= 1'b1;
            if (wr_cfg1) begin
                pcfg <= hwdata[`ADCSEQ_CFG1_PCFG];
                vref <= hwdata[`ADCSEQ_CFG1_VREF];
            end else if (!strap_done) begin
                pcfg[0] <= !portb_analog_default;
            end
            if (wr_cfg2) begin
                just <= hwdata[`ADCSEQ_CFG2_JUST];
                acqt <= hwdata[`ADCSEQ_CFG2_ACQT];
                adcs <= hwdata[`ADCSEQ_CFG2_ADCS];
            end
        end
    end

    // Pin-facing outputs, one flop each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            timer_clear <= 1'b0;
            array_discharge <= 1'b0;
            sample_en <= 1'b0;
            channel_out <= 4'h0;
        end else begin
            irq <= |(next_status & next_mask);
            timer_clear <= trig_hit;
            // Discharge occupies the whole post-conversion wait
            array_discharge <= next_state == ST_WAIT;
            // Any selected pin is sampled, analog or digital
            sample_en <= next_state == ST_SAMPLE || next_state == ST_ACQ;
            channel_out <= wr_ctrl ? hwdata[`ADCSEQ_CTRL_CHS] : chs;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_abort_keep;
        in_conv && !go && !wr_hi && !wr_lo |=>
            $stable(res_hi) && $stable(res_lo) && status[1];
    endproperty
    a_abort_keep: assert property (p_abort_keep)
        else $error("result changed on abort");

    property p_done;
        complete && !trig_go && !wr_ctrl |=> !go && status[0] && state == ST_WAIT;
    endproperty
    a_done: assert property (p_done)
        else $error("completion did not clear go and set flag");

    property p_wait_two;
        state == ST_WAIT && tad_tick && last_wait && on |=> state == ST_SAMPLE;
    endproperty
    a_wait_two: assert property (p_wait_two)
        else $error("wait did not end after two periods");

    property p_trig_on;
        trig_hit && on && !wr_ctrl |=> go;
    endproperty
    a_trig_on: assert property (p_trig_on)
        else $error("trigger did not set go");

    property p_trig_clr;
        trig_hit |=> timer_clear ##1 !timer_clear || $past(trig_hit);
    endproperty
    a_trig_clr: assert property (p_trig_clr)
        else $error("trigger did not clear timer");

    // An abort inside the delay is legal, so go and on must stay up
    property p_manual;
        state == ST_SAMPLE && go && on && acqt == 3'h0 ##1 (go && on) [*4]
            |-> state == ST_DELAY ##1 state == ST_CONV;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual start not delayed one instruction");

    property p_acq4;
        state == ST_ACQ && acqt == 3'h2 && tad_tick && cnt == 5'h03 && go && on
            |=> state == ST_CONV;
    endproperty
    a_acq4: assert property (p_acq4)
        else $error("acquisition of four periods did not convert");

    property p_discharge;
        $rose(sample_en) |-> $past(array_discharge);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("sampling began without discharge");

    property p_trig_off;
        trig_hit && !on && !wr_ctrl |=> !go && timer_clear;
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("trigger set go while converter off");

    // Read data was latched with the pin map of the address phase
    property p_port_zero;
        aph && !hwrite && haddr[7:0] == `ADCSEQ_PORT_OFF
            |=> (hrdata[NCH-1:0] & $past(analog)) == '0;
    endproperty
    a_port_zero: assert property (p_port_zero)
        else $error("analog pin read as nonzero");

    property p_result;
        complete |=> {res_hi, res_lo} == ($past(just) ?
            {6'h00, $past(sar_code)} : {$past(sar_code), 6'h00});
    endproperty
    a_result: assert property (p_result)
        else $error("result bytes do not hold the finished code");

    c_complete: cover property (complete);
    c_trig_off: cover property (trig_hit && !on);
    c_abort: cover property (in_conv && !go);
    c_trig_start: cover property (trig_go ##[1:40] state == ST_CONV);
endmodule : adcseq_top

//--- pkg/adcseq_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCSEQ_DEFINES_SVH
`define ADCSEQ_DEFINES_SVH
`define ADCSEQ_RES_HI_OFF 8'h00
`define ADCSEQ_RES_LO_OFF 8'h04
`define ADCSEQ_CTRL_OFF 8'h08
`define ADCSEQ_CFG1_OFF 8'h0c
`define ADCSEQ_CFG2_OFF 8'h10
`define ADCSEQ_STAT_OFF 8'h14
`define ADCSEQ_MASK_OFF 8'h18
`define ADCSEQ_PORT_OFF 8'h1c
`define ADCSEQ_CTRL_ON 0
`define ADCSEQ_CTRL_GO 1
`define ADCSEQ_CTRL_CHS 5:2
`define ADCSEQ_CFG1_PCFG 3:0
`define ADCSEQ_CFG1_VREF 5:4
`define ADCSEQ_CFG2_ADCS 2:0
`define ADCSEQ_CFG2_ACQT 5:3
`define ADCSEQ_CFG2_JUST 7
`define ADCSEQ_ST_DONE 0
`define ADCSEQ_ST_ABORT 1
`define ADCSEQ_TRIG_MODE 4'hb
`define ADCSEQ_PCFG_RST 4'h0
`define ADCSEQ_CHANNELS 13
`define ADCSEQ_PCFG_NONE 5'h0f
`define ADCSEQ_WAIT_TAD 2
`define ADCSEQ_CONV_TAD 11
`define ADCSEQ_INSTR_TOSC 4
`define ADCSEQ_ACQ_TAD_1 2
`define ADCSEQ_ACQ_TAD_2 4
`define ADCSEQ_ACQ_TAD_3 6
`define ADCSEQ_ACQ_TAD_4 8
`define ADCSEQ_ACQ_TAD_5 12
`define ADCSEQ_ACQ_TAD_6 16
`define ADCSEQ_ACQ_TAD_7 20
`endif

//--- pkg/adcseq_pkg.sv
// Types and the acquisition table of the conversion sequencer
`include "adcseq_defines.svh"
package adcseq_pkg;
    typedef enum logic [5:0] {
        ST_OFF = 6'b000001,
        ST_WAIT = 6'b000010,
        ST_SAMPLE = 6'b000100,
        ST_ACQ = 6'b001000,
        ST_DELAY = 6'b010000,
        ST_CONV = 6'b100000
    } adcseq_state_t;

    function automatic logic [4:0] adcseq_acq_tads(input logic [2:0] sel);
        case (sel)
            3'h1: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_1);
            3'h2: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_2);
            3'h3: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_3);
            3'h4: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_4);
            3'h5: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_5);
            3'h6: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_6);
            3'h7: adcseq_acq_tads = 5'(`ADCSEQ_ACQ_TAD_7);
            default: adcseq_acq_tads = 5'h00;
        endcase
    endfunction : adcseq_acq_tads
endpackage : adcseq_pkg

//--- core/adcseq_tad_gen.sv
// Conversion-bit period tick generator
`timescale 1ns/1ps
module adcseq_tad_gen import adcseq_pkg::*; #(
    parameter int DIV_W = 7
) (
    input wire logic clk, // System clock, one oscillator period
    input wire logic rst_n, // Async reset, active low
    input wire logic restart, // Realign the period to this cycle
    input wire logic [2:0] clk_sel, // conversion_clock_select
    input wire logic rc_tick, // Period pulse of internal_rc_clock
    output logic tad_tick // One pulse per conversion-bit period
);
    logic [DIV_W-1:0] cnt;
    wire [2:0] shift = {clk_sel[1:0], 1'b0} + {2'b00, clk_sel[2]};
    wire [DIV_W-1:0] div = DIV_W'(2) << shift;
    wire use_rc = (clk_sel[1:0] == 2'b11);
    wire wrap = (cnt == div - DIV_W'(1));

    // Oscillator divides by 2..64; x11 follows the RC source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            tad_tick <= 1'b0;
        end else begin
            cnt <= (restart || wrap) ? '0 : cnt + DIV_W'(1);
            tad_tick <= !restart && (use_rc ? rc_tick : wrap);
        end
    end
endmodule : adcseq_tad_gen

//--- core/adcseq_sar.sv
// Successive-approximation register, one bit decided per bit period
`timescale 1ns/1ps
module adcseq_sar import adcseq_pkg::*; #(
    parameter int BITS = 10
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic start, // Pulse: begin a conversion
    input wire logic tad_tick, // Bit period pulse
    input wire logic cmp_high, // Comparator: input at or above trial
    output logic [BITS-1:0] code, // Trial and final code
    output logic done // Pulse: code holds the result
);
    logic [3:0] step;
    logic busy;
    wire [3:0] bitn = 4'(BITS) - step;
    wire [BITS-1:0] m = {{(BITS-1){1'b0}}, 1'b1} << bitn;

    // First period is setup, then one bit per period: 11 in all
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step <= 4'h0;
            busy <= 1'b0;
            code <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                step <= 4'h0;
                code <= '0;
            end else if (busy && tad_tick) begin
                if (step == 4'h0) begin
                    code <= {1'b1, {(BITS-1){1'b0}}};
                end else begin
                    code <= (cmp_high ? code : code & ~m) | (m >> 1);
                end
                if (step == 4'(`ADCSEQ_CONV_TAD - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                step <= step + 4'h1;
            end
        end
    end
endmodule : adcseq_sar

//--- verification/adcseq_pins_model.sv
// Channel pins, comparator input and compare-unit trigger
`timescale 1ns/1ps
module adcseq_pins_model (
    input wire logic clk, // System clock
    input wire logic sample_en, // Hold capacitor tracks the input
    input wire logic [3:0] channel_out, // Selected channel
    input wire logic [9:0] sar_code, // Trial code from the block
    output logic [12:0] pin_level, // Digital level of each pin
    output logic [3:0] compare_two_mode, // Compare unit two mode
    output logic special_event_trig, // Compare unit event pulse
    output logic rc_tick, // Internal RC period pulse
    output logic cmp_high // Held input at or above trial
);
    logic [9:0] held = 10'h000;
    logic [3:0] rc_cnt = 4'h0;

    function automatic logic [9:0] level(input logic [3:0] ch);
        level = (ch < 4'hd) ? 10'(ch * 71 + 347) : 10'h000;
    endfunction : level

    initial begin
        compare_two_mode = 4'h0;
        special_event_trig = 1'b0;
    end

    // Fixed levels; a pin left as an output shows up here too
    assign pin_level = 13'h1a5b;
    assign rc_tick = (rc_cnt == 4'h9);
    assign cmp_high = (held >= sar_code);

    always @(posedge clk) begin
        rc_cnt <= (rc_cnt == 4'h9) ? 4'h0 : rc_cnt + 4'h1;
        if (sample_en === 1'b1) begin
            held <= level(channel_out);
        end
    end

    task automatic fire(input logic [3:0] mode);
        @(posedge clk);
        compare_two_mode <= mode;
        special_event_trig <= 1'b1;
        @(posedge clk);
        special_event_trig <= 1'b0;
    endtask : fire
endmodule : adcseq_pins_model

//--- verification/tb_top.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`include "adcseq_defines.svh"
module tb_top;
    logic clk, rst_n, hsel, hwrite, strap, irq, tclr, dis, smp;
    logic hreadyout, hresp, trig, rc_tick, cmp_high;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [12:0] pins_lvl;
    logic [3:0] mode, chan;
    logic [9:0] code;
    int num_errors = 0;
    int cmp_count = 0;
    int clr_cnt = 0;

    adcseq_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .portb_analog_default(strap), .pin_level(pins_lvl),
        .compare_two_mode(mode), .special_event_trig(trig),
        .rc_tick(rc_tick), .cmp_high(cmp_high), .irq(irq),
        .timer_clear(tclr), .array_discharge(dis), .sample_en(smp),
        .channel_out(chan), .sar_code(code));

    adcseq_pins_model pins (.clk(clk), .sample_en(smp), .channel_out(chan),
        .sar_code(code), .pin_level(pins_lvl), .compare_two_mode(mode),
        .special_event_trig(trig), .rc_tick(rc_tick), .cmp_high(cmp_high));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (tclr === 1'b1) clr_cnt <= clr_cnt + 1;
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk);
        while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk);
        while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(a, 1'b0, 32'h0, d);
    endtask : rd

    task automatic do_reset(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset

    // Discharge must be seen before sampling comes back
    task automatic resume(input int t);
        int n;
        logic d;
        n = 0;
        d = 1'b0;
        while (smp !== 1'b1 && n < 400) begin
            @(posedge clk);
            d |= (dis === 1'b1);
            n++;
        end
        chk("discharge", d, 1'h1);
        chk("resume", n <= 3 * t + 8, 1'h1);
    endtask : resume

    task automatic conv(input logic [3:0] ch, input logic [2:0] cs,
            input logic [2:0] acq, input logic just, input logic trg);
        int n;
        int t;
        int a;
        logic [31:0] r;
        logic [9:0] v;
        t = (cs[1:0] == 2'h3) ? 10 : 2 << {cs[1:0], cs[2]};
        a = (acq == 3'h2) ? 4 : 0;
        v = pins.level(ch);
        n = 0;
        wr(`ADCSEQ_CFG2_OFF, {24'h0, just, 1'h0, acq, cs});
        wr(`ADCSEQ_MASK_OFF, 32'h1);
        wr(`ADCSEQ_CTRL_OFF, {26'h0, ch, 1'h0, 1'h1});
        if (trg) pins.fire(4'hb);
        else wr(`ADCSEQ_CTRL_OFF, {26'h0, ch, 2'h3});
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("time", n >= (11 + a) * t && n <= (12 + a) * t + 14, 1'h1);
        resume(t);
        rd(`ADCSEQ_RES_HI_OFF, r);
        chk("res hi", r, just ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
        rd(`ADCSEQ_RES_LO_OFF, r);
        chk("res lo", r, just ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0});
        rd(`ADCSEQ_CTRL_OFF, r);
        chk("go", r, {26'h0, ch, 2'h1});
        wr(`ADCSEQ_STAT_OFF, 32'h3);
    endtask : conv

    task automatic t_reset();
        logic [31:0] r;
        rd(`ADCSEQ_CFG1_OFF, r);
        chk("cfg1 analog", r, 32'h0);
        rd(`ADCSEQ_CFG2_OFF, r);
        chk("cfg2", r, 32'h0);
        rd(`ADCSEQ_CTRL_OFF, r);
        chk("ctrl", r, 32'h0);
        rd(8'h20, r);
        chk("unmapped", r, 32'h0);
        chk("okay", hresp, 32'h0);
        do_reset(1'b0);
        rd(`ADCSEQ_CFG1_OFF, r);
        chk("cfg1 digital", r, 32'h1);
        wr(`ADCSEQ_CTRL_OFF, 32'h1);
        resume(2);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ports();
        logic [3:0] cfgs [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
        logic [12:0] e;
        logic [31:0] r;
        foreach (cfgs[k]) begin
            wr(`ADCSEQ_CFG1_OFF, {28'h0, cfgs[k]});
            for (int i = 0; i < 13; i++) begin
                e[i] = (i + cfgs[k] < 15) ? 1'b0 : pins_lvl[i];
            end
            rd(`ADCSEQ_PORT_OFF, r);
            chk("port view", r, {19'h0, e});
        end
        $display("test ports done");
    endtask : t_ports

    task automatic t_clocks();
        logic [2:0] sel [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
        foreach (sel[i]) conv(4'(2 * i), sel[i], 3'h0, i[0], 1'b0);
        conv(4'h7, 3'h0, 3'h2, 1'b1, 1'b0);
        $display("test clocks done");
    endtask : t_clocks

    task automatic t_abort();
        logic [31:0] r;
        wr(`ADCSEQ_RES_HI_OFF, 32'h5a);
        wr(`ADCSEQ_RES_LO_OFF, 32'hc3);
        wr(`ADCSEQ_CFG2_OFF, 32'h6);
        wr(`ADCSEQ_CTRL_OFF, 32'h13);
        repeat (100) @(posedge clk);
        wr(`ADCSEQ_CTRL_OFF, 32'h11);
        resume(64);
        rd(`ADCSEQ_STAT_OFF, r);
        chk("abort", r, 32'h2);
        rd(`ADCSEQ_RES_HI_OFF, r);
        chk("keep hi", r, 32'h5a);
        rd(`ADCSEQ_RES_LO_OFF, r);
        chk("keep lo", r, 32'hc3);
        wr(`ADCSEQ_STAT_OFF, 32'h3);
        $display("test abort done");
    endtask : t_abort

    task automatic t_trig();
        logic [31:0] r;
        int c;
        c = clr_cnt;
        wr(`ADCSEQ_CTRL_OFF, 32'h0);
        pins.fire(4'hb);
        repeat (2) @(posedge clk);
        chk("clear off", clr_cnt, c + 1);
        rd(`ADCSEQ_CTRL_OFF, r);
        chk("go off", r, 32'h0);
        pins.fire(4'h2);
        repeat (2) @(posedge clk);
        chk("other mode", clr_cnt, c + 1);
        wr(`ADCSEQ_CTRL_OFF, 32'h1);
        resume(64);
        conv(4'h9, 3'h0, 3'h0, 1'b1, 1'b1);
        chk("clear on", clr_cnt, c + 2);
        $display("test trigger done");
    endtask : t_trig

    task automatic t_irq();
        logic [31:0] r;
        wr(`ADCSEQ_MASK_OFF, 32'h0);
        wr(`ADCSEQ_CTRL_OFF, 32'h7);
        repeat (80) @(posedge clk);
        chk("irq masked", irq, 1'h0);
        rd(`ADCSEQ_STAT_OFF, r);
        chk("done flag", r, 32'h1);
        wr(`ADCSEQ_MASK_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq on", irq, 1'h1);
        wr(`ADCSEQ_STAT_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq off", irq, 1'h0);
        $display("test irq done");
    endtask : t_irq

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        rst_n = 1'b0;
        strap = 1'b1;
        do_reset(1'b1);
        t_reset();
        t_ports();
        t_clocks();
        t_abort();
        t_trig();
        t_irq();
        end_of_test();
    end
endmodule : tb_top
